// ---- dv/uartsc_peer.sv ----
// Model of the serial device that sits on the far side of the port's line pins.
`timescale 1ns/100ps
`default_nettype none
module uartsc_peer #(
    parameter int BIT_CLKS = 8
) (
    input  wire logic i_sys_clk,
    input  wire logic i_line,
    output logic      o_line
);
    initial o_line = 1'b1;
    // The line rests high; a frame is start, eight bits low bit first, then the stop level given.
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT_CLKS) @(posedge i_sys_clk);
        end
        o_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge i_sys_clk);
    endtask
    task automatic take(output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        while (i_line !== 1'b0 && n < 2000) begin
            @(posedge i_sys_clk);
            n++;
        end
        ok = (n < 2000);
        repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            d[i] = i_line;
            repeat (BIT_CLKS) @(posedge i_sys_clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/uartsc_test.sv ----
// Self-checking bench for the UART status and control block.
`timescale 1ns/100ps
`default_nettype none
`include "uartsc_cfg.svh"
module uart_status_and_control_test;
    logic        i_sys_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [5:0]  i_avs_address = 6'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest, o_rx_shared_pin_out, o_rx_shared_pin_oe, o_tx_pin, o_tx_pin_oe;
    logic        peer_tx, line, d_ok;
    logic [7:0]  rd, got;
    logic [3:0]  par_v = 4'h6;
    int          errors = 0;
    int          total_checks = 0;
    localparam logic [21:0] ROWS [11] = '{{`UARTSC_A_CTRL_WIRE, 8'hff, 8'h07}, {`UARTSC_A_CTRL_WIRE, 8'h00, 8'h00},
        {`UARTSC_A_FIFO, 8'hff, 8'h3f}, {`UARTSC_A_FIFO, 8'h00, 8'h00}, {`UARTSC_A_BAUD_HI, 8'h00, 8'h00},
        {`UARTSC_A_BAUD_LO, 8'h07, 8'h07}, {`UARTSC_A_STATUS, 8'hff, 8'h0b}, {`UARTSC_A_RX_FILL_COUNT, 8'hff, 8'h00},
        {`UARTSC_A_CTRL_MAIN, 8'h39, 8'h38}, {`UARTSC_A_CTRL_MAIN, 8'h00, 8'h00}, {6'h24, 8'hff, 8'h00}};
    always #10 i_sys_clk = ~i_sys_clk;
    // The shared pin carries the port's drive while it is enabled, the device's otherwise.
    assign line = o_rx_shared_pin_oe ? o_rx_shared_pin_out : peer_tx;
    uartsc_top #(.DEPTH(4)) DUT (.i_sys_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_rx_shared_pin(line), .o_rx_shared_pin_out,
        .o_rx_shared_pin_oe, .o_tx_pin, .o_tx_pin_oe);
    uartsc_peer #(.BIT_CLKS(8)) P (.i_sys_clk, .i_line(o_tx_pin_oe ? o_tx_pin : 1'b1), .o_line(peer_tx));
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= {24'h0, d};
        @(posedge i_sys_clk);
        while (o_avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge i_sys_clk);
            n++;
        end
        rd = o_avs_readdata[7:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_sys_clk);
        if (n >= 20) begin
            errors++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    task automatic rxw(input logic [7:0] d, input logic stp, input logic [7:0] st, input logic [7:0] de);
        P.send(d, stp);
        rdc(`UARTSC_A_STATUS, st);
        rdc(`UARTSC_A_DATA, de);
        rdc(`UARTSC_A_STATUS, 8'h0b);
    endtask
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        for (int i = 0; i < 11; i++) begin
            wr(ROWS[i][21:16], ROWS[i][15:8]);
            rdc(ROWS[i][21:16], ROWS[i][7:0]);
        end
        wr(`UARTSC_A_CTRL_MAIN, 8'h80);
        wr(`UARTSC_A_CTRL_EN, 8'hc0);
        rdc(`UARTSC_A_STATUS, 8'h0b);
        chk({7'h0, o_tx_pin_oe}, 8'h01);
        fork
            rxw(8'ha5, 1'b1, 8'h0f, 8'ha5);
            begin
                repeat (30) @(posedge i_sys_clk);
                rdc(`UARTSC_A_STATUS, 8'h03);
            end
        join
        rxw(8'h5a, 1'b0, 8'h2f, 8'h5a);
        for (int k = 0; k < 4; k++) begin
            wr(`UARTSC_A_CTRL_MAIN, 8'ha0 | 8'(k << 3));
            rxw({par_v[k], 7'h35}, 1'b1, 8'h0f, 8'h35);
        end
        wr(`UARTSC_A_CTRL_MAIN, 8'ha0);
        rxw(8'hb5, 1'b1, 8'h8f, 8'h35);
        // Nine-bit frame: the stop argument of the peer lands in the ninth bit, its idle bit is the stop.
        wr(`UARTSC_A_CTRL_MAIN, 8'hc0);
        P.send(8'h5a, 1'b1);
        rdc(`UARTSC_A_STATUS, 8'h0f);
        rdc(`UARTSC_A_CTRL_MAIN, 8'hc2);
        rdc(`UARTSC_A_DATA, 8'h5a);
        wr(`UARTSC_A_CTRL_MAIN, 8'h80);
        for (int i = 0; i < 5; i++) P.send(8'h10 + 8'(i), 1'b1);
        rdc(`UARTSC_A_RX_FILL_COUNT, 8'h04);
        rdc(`UARTSC_A_STATUS, 8'h1f);
        rdc(`UARTSC_A_DATA, 8'h10);
        for (int i = 1; i < 4; i++) begin
            rdc(`UARTSC_A_STATUS, 8'h0f);
            rdc(`UARTSC_A_DATA, 8'h10 + 8'(i));
        end
        rdc(`UARTSC_A_STATUS, 8'h0b);
        fork
            P.take(got, d_ok);
            begin
                wr(`UARTSC_A_DATA, 8'h3c);
                rdc(`UARTSC_A_STATUS, 8'h09);
            end
        join
        chk(got, 8'h3c);
        chk({7'h0, d_ok}, 8'h01);
        repeat (40) @(posedge i_sys_clk);
        rdc(`UARTSC_A_STATUS, 8'h0b);
        wr(`UARTSC_A_DATA, 8'h55);
        fork
            P.send(8'hc3, 1'b1);
            begin
                repeat (40) @(posedge i_sys_clk);
                wr(`UARTSC_A_CTRL_MAIN, 8'h00);
            end
        join
        rdc(`UARTSC_A_STATUS, 8'h0b);
        rdc(`UARTSC_A_CTRL_EN, 8'h00);
        rdc(`UARTSC_A_BAUD_LO, 8'h07);
        chk({6'h0, o_rx_shared_pin_oe, o_tx_pin_oe}, 8'h00);
        wr(`UARTSC_A_CTRL_MAIN, 8'h80);
        wr(`UARTSC_A_CTRL_EN, 8'hc0);
        rxw(8'h66, 1'b1, 8'h0f, 8'h66);
        wr(`UARTSC_A_CTRL_WIRE, 8'h01);
        repeat (2) @(posedge i_sys_clk);
        chk({6'h0, o_rx_shared_pin_oe, o_tx_pin_oe}, 8'h00);
        wr(`UARTSC_A_CTRL_EN, 8'h80);
        repeat (2) @(posedge i_sys_clk);
        chk({6'h0, o_rx_shared_pin_oe, o_tx_pin_oe}, 8'h03);
        finish_test();
    end
endmodule
`default_nettype wire

// ---- hdl/uartsc_top.sv ----
// UART status flags, main control, frame engine and Avalon-MM register slave.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "uartsc_cfg.svh"
module uartsc_top
    import uartsc_pkg::*;
#(
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // Avalon-MM slave.
    input  wire logic [`UARTSC_AW-1:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Serial pins.
    input  wire logic        i_rx_shared_pin,
    output logic             o_rx_shared_pin_out,
    output logic             o_rx_shared_pin_oe,
    output logic             o_tx_pin,
    output logic             o_tx_pin_oe
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    function automatic logic par_bit(input logic [1:0] kind, input logic [7:0] x);
        case (kind)
            `UARTSC_PAR_EVEN: par_bit = ^x;
            `UARTSC_PAR_ODD:  par_bit = ~^x;
            `UARTSC_PAR_MARK: par_bit = 1'b1;
            default:          par_bit = 1'b0;
        endcase
    endfunction

    logic [7:0] st_q, arm_q, cm_q, en_q, wi_q, bh_q, bl_q, fi_q, hold_q;
    logic       hold_full_q, tx8_q, rx_prev_q, rx_done_q;
    logic [15:0] rx_cnt_q, tx_cnt_q;
    logic [3:0] rx_bit_q, tx_left_q;
    logic [11:0] tx_sh_q;
    logic [8:0] rx_sh_q;
    logic       rx_stop_q, rx_noise_q, rx_framing_err_flag_q;
    uartsc_rx_state_t rx_st_q;
    uartsc_rx_word_t  rx_ent_q;
    uartsc_rx_word_t  fifo_mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [CW-1:0] cnt_q;

    // Bus handshake: waitrequest drops for one cycle, the access acts when it is seen low.
    logic req, act, act_rd, act_wr;
    assign req    = i_avs_read | i_avs_write;
    assign act    = req & ~o_avs_waitrequest;
    assign act_rd = act & i_avs_read;
    assign act_wr = act & i_avs_write;

    logic off, nine, par_on, rx_act, tx_act, rx_tick, tx_tick, rxin, tx_busy;
    logic [15:0] div;
    assign off     = ~cm_q[`UARTSC_CM_ON];
    assign nine    = cm_q[`UARTSC_CM_NINE];
    assign par_on  = cm_q[`UARTSC_CM_PAR];
    assign div     = {bh_q, bl_q};
    assign rx_act  = ~off & en_q[`UARTSC_EN_RX];
    assign tx_act  = ~off & en_q[`UARTSC_EN_TX] & ~(wi_q[`UARTSC_WI_ONEW] & en_q[`UARTSC_EN_RX]);
    assign rx_tick = (rx_cnt_q == 16'h0000);
    assign tx_tick = (tx_cnt_q == 16'h0000);
    assign rxin    = i_rx_shared_pin ^ wi_q[`UARTSC_WI_RXINV];
    assign tx_busy = (tx_left_q != 4'h0);

    logic dat_rd, dat_wr, st_rd, fifo_push, fifo_pop, ovr_evt, tx_load, tx_en_set;
    logic [CW-1:0] cnt_next, trig;
    assign dat_rd    = act_rd & (i_avs_address == `UARTSC_A_DATA);
    assign dat_wr    = act_wr & (i_avs_address == `UARTSC_A_DATA);
    assign st_rd     = act_rd & (i_avs_address == `UARTSC_A_STATUS);
    assign fifo_pop  = dat_rd & (cnt_q != '0);
    assign ovr_evt   = rx_done_q & (cnt_q == CW'(DEPTH));
    assign fifo_push = rx_done_q & ~ovr_evt & ~st_q[`UARTSC_ST_OVR];
    assign cnt_next  = cnt_q + CW'(fifo_push) - CW'(fifo_pop);
    assign trig      = CW'(fi_q[1:0]) + CW'(1);
    assign tx_load   = tx_act & ~tx_busy & hold_full_q;
    assign tx_en_set = act_wr & (i_avs_address == `UARTSC_A_CTRL_EN) & i_avs_writedata[`UARTSC_EN_TX];

    // Register read mux; the status register has no write path at all.
    logic [7:0] rd_mux;
    always_comb begin
        case (i_avs_address)
            `UARTSC_A_STATUS:    rd_mux = st_q;
            `UARTSC_A_CTRL_MAIN: rd_mux = {cm_q[7:2], (cnt_q != '0) & fifo_mem[rp_q].ninth, 1'b0};
            `UARTSC_A_CTRL_EN:   rd_mux = en_q;
            `UARTSC_A_CTRL_WIRE: rd_mux = wi_q;
            `UARTSC_A_DATA:      rd_mux = (cnt_q != '0) ? fifo_mem[rp_q].data : 8'h00;
            `UARTSC_A_BAUD_HI:   rd_mux = bh_q;
            `UARTSC_A_BAUD_LO:   rd_mux = bl_q;
            `UARTSC_A_FIFO:      rd_mux = fi_q;
            `UARTSC_A_RX_FILL_COUNT:     rd_mux = 8'(cnt_q);
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (req & o_avs_waitrequest) begin
                o_avs_readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Control registers; disable clears only enables and break, the rest is kept.
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cm_q  <= 8'h00;
            en_q  <= 8'h00;
            wi_q  <= 8'h00;
            bh_q  <= 8'h00;
            bl_q  <= 8'h00;
            fi_q  <= 8'h00;
            tx8_q <= 1'b0;
        end else begin
            if (act_wr) begin
                case (i_avs_address)
                    `UARTSC_A_CTRL_MAIN: begin
                        cm_q  <= i_avs_writedata[7:0] & `UARTSC_CM_WMASK;
                        tx8_q <= i_avs_writedata[`UARTSC_CM_TX8];
                    end
                    `UARTSC_A_CTRL_EN:   en_q <= i_avs_writedata[7:0];
                    `UARTSC_A_CTRL_WIRE: wi_q <= i_avs_writedata[7:0] & `UARTSC_WI_MASK;
                    `UARTSC_A_BAUD_HI:   bh_q <= i_avs_writedata[7:0];
                    `UARTSC_A_BAUD_LO:   bl_q <= i_avs_writedata[7:0];
                    `UARTSC_A_FIFO:      fi_q <= i_avs_writedata[7:0] & `UARTSC_FI_MASK;
                    default: begin
                    end
                endcase
            end
            if (off) begin
                en_q[`UARTSC_EN_TX]  <= 1'b0;
                en_q[`UARTSC_EN_RX]  <= 1'b0;
                cm_q[`UARTSC_CM_BRK] <= 1'b0;
            end
        end
    end

    // Receiver: mid-bit sampling, a level change across the sample point counts as noise.
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_st_q    <= UARTSC_RX_IDLE;
            rx_cnt_q   <= 16'h0000;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 9'h000;
            rx_stop_q  <= 1'b0;
            rx_noise_q <= 1'b0;
            rx_framing_err_flag_q  <= 1'b0;
            rx_prev_q  <= 1'b1;
            rx_done_q  <= 1'b0;
            rx_ent_q   <= '0;
        end else begin
            rx_prev_q <= rxin;
            rx_done_q <= 1'b0;
            rx_cnt_q  <= rx_tick ? div : rx_cnt_q - 16'h0001;
            if (rx_tick && rx_st_q != UARTSC_RX_IDLE) begin
                rx_noise_q <= rx_noise_q | (rxin != rx_prev_q);
            end
            if (!rx_act) begin
                rx_st_q  <= UARTSC_RX_IDLE;
                rx_cnt_q <= 16'h0000;
            end else begin
                case (rx_st_q)
                    UARTSC_RX_IDLE: begin
                        if (!rxin && rx_prev_q) begin
                            rx_st_q    <= UARTSC_RX_START;
                            rx_cnt_q   <= {1'b0, div[15:1]};
                            rx_noise_q <= 1'b0;
                            rx_framing_err_flag_q  <= 1'b0;
                        end
                    end
                    UARTSC_RX_START: begin
                        if (rx_tick) begin
                            rx_st_q  <= rxin ? UARTSC_RX_IDLE : UARTSC_RX_DATA;
                            rx_bit_q <= 4'h0;
                        end
                    end
                    UARTSC_RX_DATA: begin
                        if (rx_tick) begin
                            rx_sh_q  <= {rxin, rx_sh_q[8:1]};
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == (nine ? 4'h8 : 4'h7)) begin
                                rx_st_q   <= UARTSC_RX_STOP;
                                rx_stop_q <= en_q[`UARTSC_EN_STOPS];
                            end
                        end
                    end
                    UARTSC_RX_STOP: begin
                        if (rx_tick) begin
                            rx_framing_err_flag_q <= rx_framing_err_flag_q | ~rxin;
                            rx_stop_q <= 1'b0;
                            if (!rx_stop_q) begin
                                rx_st_q         <= UARTSC_RX_IDLE;
                                rx_done_q       <= 1'b1;
                                rx_ent_q.framing_err_flag   <= rx_framing_err_flag_q | ~rxin;
                                rx_ent_q.noise  <= rx_noise_q;
                                if (nine) begin
                                    rx_ent_q.ninth <= rx_sh_q[8] & ~par_on;
                                    rx_ent_q.data  <= rx_sh_q[7:0];
                                    rx_ent_q.parity_err_flag  <= par_on & (rx_sh_q[8] != par_bit(cm_q[4:3], rx_sh_q[7:0]));
                                end else begin
                                    rx_ent_q.ninth <= 1'b0;
                                    rx_ent_q.data  <= {rx_sh_q[8] & ~par_on, rx_sh_q[7:1]};
                                    rx_ent_q.parity_err_flag  <= par_on & (rx_sh_q[8] != par_bit(cm_q[4:3], {1'b0, rx_sh_q[7:1]}));
                                end
                            end
                        end
                    end
                    default: rx_st_q <= UARTSC_RX_IDLE;
                endcase
            end
        end
    end

    // Receive FIFO; a disable flushes it.
    always_ff @(posedge i_sys_clk) begin
        if (fifo_push) begin
            fifo_mem[wp_q] <= rx_ent_q;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (off) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_q + AW'(fifo_push);
            rp_q  <= rp_q + AW'(fifo_pop);
            cnt_q <= cnt_next;
        end
    end

    // Transmitter: holding register feeding a shift register with two stop bits.
    logic [8:0] tx_w9;
    always_comb begin
        tx_w9 = nine ? {tx8_q, hold_q} : {1'b1, hold_q};
        if (par_on && nine) begin
            tx_w9[8] = par_bit(cm_q[4:3], hold_q);
        end else if (par_on) begin
            tx_w9[7] = par_bit(cm_q[4:3], {1'b0, hold_q[6:0]});
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
            tx_sh_q     <= 12'hfff;
            tx_left_q   <= 4'h0;
            tx_cnt_q    <= 16'h0000;
        end else if (!tx_act) begin
            hold_full_q <= 1'b0;
            tx_left_q   <= 4'h0;
            tx_cnt_q    <= 16'h0000;
        end else begin
            if (dat_wr) begin
                hold_q      <= i_avs_writedata[7:0];
                hold_full_q <= 1'b1;
            end else if (tx_load) begin
                hold_full_q <= 1'b0;
            end
            if (tx_load) begin
                tx_sh_q   <= {2'b11, tx_w9, 1'b0};
                tx_left_q <= nine ? 4'hc : 4'hb;
                tx_cnt_q  <= div;
            end else if (tx_busy) begin
                tx_cnt_q <= tx_tick ? div : tx_cnt_q - 16'h0001;
                if (tx_tick) begin
                    tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                    tx_left_q <= tx_left_q - 4'h1;
                end
            end
        end
    end

    // Pin drivers; the line rests high, break holds it low whenever no frame is shifting.
    logic tx_line;
    assign tx_line = tx_busy ? tx_sh_q[0] : ~cm_q[`UARTSC_CM_BRK];
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_pin            <= 1'b1;
            o_tx_pin_oe         <= 1'b0;
            o_rx_shared_pin_out <= 1'b1;
            o_rx_shared_pin_oe  <= 1'b0;
        end else begin
            o_tx_pin            <= tx_line ^ wi_q[`UARTSC_WI_TXINV];
            o_rx_shared_pin_out <= tx_line ^ wi_q[`UARTSC_WI_TXINV];
            o_tx_pin_oe         <= tx_act;
            o_rx_shared_pin_oe  <= tx_act & wi_q[`UARTSC_WI_ONEW];
        end
    end

    // Status flags: a hardware set wins over a software clear, except that a data write blocks the set of the transmit-idle flag.
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q  <= `UARTSC_ST_RST;
            arm_q <= 8'h00;
        end else if (off) begin
            st_q  <= `UARTSC_ST_RST;
            arm_q <= 8'h00;
        end else begin
            if (st_rd) begin
                arm_q <= o_avs_readdata[7:0];
            end else if (dat_rd || dat_wr) begin
                arm_q <= 8'h00;
            end
            if ((dat_rd || dat_wr) && arm_q[7:4] != 4'h0) begin
                st_q[7:4] <= st_q[7:4] & ~arm_q[7:4];
            end
            if (fifo_push) begin
                if (rx_ent_q.parity_err_flag) st_q[`UARTSC_ST_PARITY_ERR_FLAG] <= 1'b1;
                if (rx_ent_q.noise) st_q[`UARTSC_ST_NOISE] <= 1'b1;
                if (rx_ent_q.framing_err_flag) st_q[`UARTSC_ST_FRAMING_ERR_FLAG] <= 1'b1;
            end
            if (ovr_evt) begin
                st_q[`UARTSC_ST_OVR] <= 1'b1;
            end
            st_q[`UARTSC_ST_RXIDLE] <= (rx_st_q == UARTSC_RX_IDLE);
            if (fifo_push && cnt_next >= trig) begin
                st_q[`UARTSC_ST_RXAV] <= 1'b1;
            end else if (dat_rd && arm_q[`UARTSC_ST_RXAV] && cnt_next == '0) begin
                st_q[`UARTSC_ST_RXAV] <= 1'b0;
            end
            if (st_q[`UARTSC_ST_TXEMPTY] && !tx_busy && !hold_full_q && !dat_wr && !cm_q[`UARTSC_CM_BRK]) begin
                st_q[`UARTSC_ST_TXIDLE] <= 1'b1;
            end else if (dat_wr && arm_q[`UARTSC_ST_TXIDLE]) begin
                st_q[`UARTSC_ST_TXIDLE] <= 1'b0;
            end
            if (tx_load || tx_en_set) begin
                st_q[`UARTSC_ST_TXEMPTY] <= 1'b1;
            end else if (dat_wr && arm_q[`UARTSC_ST_TXEMPTY]) begin
                st_q[`UARTSC_ST_TXEMPTY] <= 1'b0;
            end
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    status_ro_a: assert property (act_wr && i_avs_address == `UARTSC_A_STATUS && !off && !rx_done_q
        && !tx_load && !tx_en_set && !fifo_pop && (rx_st_q == UARTSC_RX_IDLE) && st_q[3] |=> $stable(st_q[7:4]))
        else $error("status changed by a write");
    overrun_hold_a: assert property (st_q[`UARTSC_ST_OVR] && !off |-> !fifo_push)
        else $error("word entered while overrun set");
    noise_ovr_a: assert property (ovr_evt && !st_q[6] && !off |=> !st_q[`UARTSC_ST_NOISE])
        else $error("noise flag set on overrun");
    err_cycle_a: assert property (fifo_push && rx_ent_q.framing_err_flag && !off |=> st_q[`UARTSC_ST_FRAMING_ERR_FLAG])
        else $error("framing flag not set with push");
    err_clear_a: assert property (dat_wr && arm_q[7] && !fifo_push && !off |=> !st_q[`UARTSC_ST_PARITY_ERR_FLAG])
        else $error("parity flag not cleared");
    off_reset_a: assert property (off |=> st_q == `UARTSC_ST_RST && cnt_q == '0 && en_q[7:6] == 2'b00)
        else $error("disable did not reset state");
    pins_float_a: assert property (off ##1 off |-> !o_tx_pin_oe && !o_rx_shared_pin_oe)
        else $error("pin driven while disabled");
    rx_wins_a: assert property (en_q[6] && wi_q[0] |=> !o_rx_shared_pin_oe)
        else $error("shared pin driven while receiving");
    tx_empty_a: assert property (tx_load && !off |=> st_q[`UARTSC_ST_TXEMPTY] && tx_busy)
        else $error("load did not set transmit empty");
    rx_avail_a: assert property (dat_rd && arm_q[2] && cnt_q == 1 && !fifo_push && !off |=> !st_q[2])
        else $error("receive flag not cleared");

    ovr_seen_c: cover property (ovr_evt);
    frame_in_c: cover property (fifo_push ##[1:1000] fifo_pop);
    tx_frame_c: cover property (tx_load ##[1:1000] st_q[`UARTSC_ST_TXIDLE]);
    off_busy_c: cover property (tx_busy && $fell(cm_q[`UARTSC_CM_ON]));
endmodule
`default_nettype wire

// ---- pkg/uartsc_cfg.svh ----
// Register offsets, field positions, reset values and codes of the UART status and control block.
`ifndef UARTSC_CFG_SVH
`define UARTSC_CFG_SVH
`define UARTSC_AW          6
`define UARTSC_A_STATUS    6'h00
`define UARTSC_A_CTRL_MAIN 6'h04
`define UARTSC_A_CTRL_EN   6'h08
`define UARTSC_A_CTRL_WIRE 6'h0c
`define UARTSC_A_DATA      6'h10
`define UARTSC_A_BAUD_HI   6'h14
`define UARTSC_A_BAUD_LO   6'h18
`define UARTSC_A_FIFO      6'h1c
`define UARTSC_A_RX_FILL_COUNT     6'h20
`define UARTSC_ST_PARITY_ERR_FLAG     7
`define UARTSC_ST_NOISE    6
`define UARTSC_ST_FRAMING_ERR_FLAG     5
`define UARTSC_ST_OVR      4
`define UARTSC_ST_RXIDLE   3
`define UARTSC_ST_RXAV     2
`define UARTSC_ST_TXIDLE   1
`define UARTSC_ST_TXEMPTY  0
`define UARTSC_CM_ON       7
`define UARTSC_CM_NINE     6
`define UARTSC_CM_PAR      5
`define UARTSC_CM_BRK      2
`define UARTSC_CM_RX8      1
`define UARTSC_CM_TX8      0
`define UARTSC_EN_TX       7
`define UARTSC_EN_RX       6
`define UARTSC_EN_STOPS    5
`define UARTSC_WI_TXINV    2
`define UARTSC_WI_RXINV    1
`define UARTSC_WI_ONEW     0
`define UARTSC_ST_RST      8'h0b
`define UARTSC_CM_WMASK    8'hfd
`define UARTSC_WI_MASK     8'h07
`define UARTSC_FI_MASK     8'h3f
`define UARTSC_PAR_EVEN    2'h0
`define UARTSC_PAR_ODD     2'h1
`define UARTSC_PAR_MARK    2'h2
`define UARTSC_PAR_SPACE   2'h3
`endif

// ---- pkg/uartsc_pkg.sv ----
// Types shared by the UART status and control block.
package uartsc_pkg;
    typedef enum logic [1:0] {
        UARTSC_RX_IDLE  = 2'b00,
        UARTSC_RX_START = 2'b01,
        UARTSC_RX_DATA  = 2'b10,
        UARTSC_RX_STOP  = 2'b11
    } uartsc_rx_state_t;
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
        logic       parity_err_flag;
        logic       noise;
        logic       framing_err_flag;
    } uartsc_rx_word_t;
endpackage
